// ### design/rh_status_pkg.sv
package rh_status_pkg;

	// ----------------------------------------
	// register command codes
	// ----------------------------------------
	localparam logic [7:0] HUB_STATUS_RD = 8'h14;
	localparam logic [7:0] HUB_STATUS_WR = 8'h94;
	localparam logic [7:0] PORT_RD_BASE = 8'h15;
	localparam logic [7:0] PORT_WR_BASE = 8'h95;
	localparam logic [7:0] CONFIG_RD = 8'h20;
	localparam logic [7:0] CONFIG_WR = 8'ha0;
	localparam logic [7:0] INT_STATUS_RD = 8'h21;
	localparam logic [7:0] INT_STATUS_WR = 8'ha1;
	localparam logic [7:0] INT_MASK_RD = 8'h22;
	localparam logic [7:0] INT_MASK_WR = 8'ha2;

	// ----------------------------------------
	// root_hub_global_status fields
	// ----------------------------------------
	localparam int HUB_CLR_WAKE_BIT = 31;
	localparam int HUB_OC_CHG_BIT = 17;
	localparam int HUB_SET_POWER_BIT = 16;
	localparam int HUB_WAKE_BIT = 15;
	localparam int HUB_OC_BIT = 1;
	localparam int HUB_CLR_POWER_BIT = 0;

	// ----------------------------------------
	// root_hub_port_status fields
	// ----------------------------------------
	localparam int PRT_CONN_BIT = 0;
	localparam int PRT_EN_BIT = 1;
	localparam int PRT_SUSP_BIT = 2;
	localparam int PRT_OC_BIT = 3;
	localparam int PRT_RST_BIT = 4;
	localparam int PRT_PWR_BIT = 8;
	localparam int PRT_LS_BIT = 9;
	localparam int PRT_CHG_LSB = 16;
	localparam int CHG_CONN = 0;
	localparam int CHG_EN = 1;
	localparam int CHG_SUSP = 2;
	localparam int CHG_OC = 3;
	localparam int CHG_RST = 4;
	// write-side command bits of the status half
	localparam int CMD_CLR_EN_BIT = 0;
	localparam int CMD_SET_EN_BIT = 1;
	localparam int CMD_SET_SUSP_BIT = 2;
	localparam int CMD_CLR_SUSP_BIT = 3;
	localparam int CMD_SET_RST_BIT = 4;
	localparam int CMD_SET_PWR_BIT = 8;
	localparam int CMD_CLR_PWR_BIT = 9;

	// ----------------------------------------
	// config and interrupt fields
	// ----------------------------------------
	localparam int CFG_PER_PORT_PWR_BIT = 0;
	localparam int CFG_OC_PER_PORT_BIT = 1;
	localparam int CFG_MASK_LSB = 2;
	localparam int CFG_COUNT_LSB = 4;
	localparam logic [1:0] CFG_COUNT_RESET = 2'h2;
	localparam int INT_RESUME_BIT = 0;
	localparam int INT_HUB_OC_BIT = 1;
	localparam int INT_CONNECT_BIT = 2;
	localparam int NUM_PORTS = 2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_FREQ_HZ = 10000000;
	localparam int PORT_RESET_MS = 10;
	localparam int PORT_RESET_CYCLES = CLK_FREQ_HZ / 1000 * PORT_RESET_MS;
	localparam int RST_W = 17;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [RST_W-1:0] rst_cnt;
		logic [4:0] chg;
		logic ls;
		logic pwr;
		logic rst;
		logic oc;
		logic susp;
		logic en;
		logic conn;
		logic pend;
		logic [31:0] pend_data;
	} port_t;

	// sense vector: oc [1:0], connect [3:2], low speed [5:4]
	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
		logic [5:0] s3;
		logic [5:0] q;
		port_t [NUM_PORTS-1:0] port;
		logic wake_en;
		logic hub_oc;
		logic hub_oc_chg;
		logic per_port_pwr;
		logic oc_per_port;
		logic [1:0] pwr_mask;
		logic [1:0] port_count;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		logic irq;
		logic resume_req;
		logic [31:0] rdata;
	} rh_state_t;

endpackage : rh_status_pkg

// ### design/root_hub_status_registers.sv
// Operation
// - hub write bit 31 clears wakeup enable
// - hub overcurrent change set by hw, write-one-clear
// - local power bits 16 and 0 read zero
// - global mode: bit 16 powers all configured ports
// - per-port mode: bit 16 powers unmasked ports
// - global mode: bit 0 unpowers all ports
// - per-port mode: bit 0 unpowers unmasked ports
// - wakeup enabled connect change resumes suspended controller
// - hub write bit 15 sets wakeup enable
// - global overcurrent flag, zero when per-port
// - hub status read 14h, write 94h
// - one port register per configured port
// - status low half, change flags high half
// - port writes wait for transaction end
// - change flags at bits 20 to 16
// - status bits 4..0, power 8, low speed 9
// - masked ports ignore global power commands; the code does this only in per-port mode, global mode powers them too
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module root_hub_status_registers
	import rh_status_pkg::*;
#(
	parameter int RESET_CYCLES = PORT_RESET_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// register port
	input wire reg_req_t bus_req,
	output logic [31:0] rd_data,
	output logic irq,
	// downstream port pins
	input wire logic [1:0] oc_sense_n,
	input wire logic [1:0] connect_sense,
	input wire logic [1:0] low_speed_sense,
	output logic [1:0] port_power,
	output logic [1:0] port_reset_out,
	// controller side
	input wire logic transaction_busy,
	input wire logic controller_suspend_state,
	output logic resume_req
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	rh_state_t st_reg;
	rh_state_t st_next;
	logic [1:0] active;
	logic [1:0] conn_evt;
	logic hub_wr;

	function automatic logic [31:0] port_word(input port_t p);
		logic [31:0] w;
		w = 32'h0;
		w[PRT_CONN_BIT] = p.conn;
		w[PRT_EN_BIT] = p.en;
		w[PRT_SUSP_BIT] = p.susp;
		w[PRT_OC_BIT] = p.oc;
		w[PRT_RST_BIT] = p.rst;
		w[PRT_PWR_BIT] = p.pwr;
		w[PRT_LS_BIT] = p.ls;
		w[PRT_CHG_LSB +: 5] = p.chg;
		return w;
	endfunction : port_word

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		port_t p;
		logic [31:0] d;
		logic apply;
		logic wr_i;
		logic [31:0] w;
		logic [2:0] int_set;
		p = '0;
		d = 32'h0;
		apply = 1'b0;
		wr_i = 1'b0;
		w = 32'h0;
		int_set = 3'h0;
		st_next = st_reg;
		st_next.resume_req = 1'b0;
		st_next.rdata = 32'h0;
		hub_wr = bus_req.wr && (bus_req.addr == HUB_STATUS_WR);

		// three-stage sense sync; q follows once stages 2 and 3 agree
		st_next.s1 = {low_speed_sense, connect_sense, ~oc_sense_n};
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int b = 0; b < 6; b++) begin
			if (st_reg.s2[b] == st_reg.s3[b]) begin
				st_next.q[b] = st_reg.s2[b];
			end
		end

		// ports beyond the configured count stay idle
		for (int i = 0; i < NUM_PORTS; i++) begin
			active[i] = (2'(i) < st_reg.port_count);
		end

		// set, clear; a set in the same write wins
		if (hub_wr && bus_req.wdata[HUB_CLR_WAKE_BIT]) begin
			st_next.wake_en = 1'b0;
		end
		if (hub_wr && bus_req.wdata[HUB_WAKE_BIT]) begin
			st_next.wake_en = 1'b1;
		end

		// global flag from sensed pins, zero when per-port
		st_next.hub_oc = !st_reg.oc_per_port && |(st_next.q[1:0] & active);
		// clear by one, hardware change wins
		if (hub_wr && bus_req.wdata[HUB_OC_CHG_BIT]) begin
			st_next.hub_oc_chg = 1'b0;
		end
		if (st_next.hub_oc != st_reg.hub_oc) begin
			st_next.hub_oc_chg = 1'b1;
			int_set[INT_HUB_OC_BIT] = 1'b1;
		end

		for (int i = 0; i < NUM_PORTS; i++) begin
			p = st_reg.port[i];
			wr_i = bus_req.wr && (bus_req.addr == PORT_WR_BASE + 8'(i)) && active[i];
			// port writes go through pending slot, applied when idle
			apply = st_reg.port[i].pend && !transaction_busy;
			d = st_reg.port[i].pend_data;
			if (apply) begin
				p.pend = wr_i;
				p.pend_data = wr_i ? bus_req.wdata : 32'h0;
			end else if (wr_i) begin
				// commands are all one-actions, so merging by or is safe
				p.pend = 1'b1;
				p.pend_data = st_reg.port[i].pend_data | bus_req.wdata;
			end
			if (apply) begin
				p.chg = p.chg & ~d[PRT_CHG_LSB +: 5];
				if (!p.conn && (d[CMD_SET_EN_BIT] || d[CMD_SET_SUSP_BIT]
						|| d[CMD_SET_RST_BIT])) begin
					p.chg[CHG_CONN] = 1'b1;
				end else begin
					if (d[CMD_SET_EN_BIT]) begin
						p.en = 1'b1;
					end
					if (d[CMD_SET_SUSP_BIT]) begin
						p.susp = 1'b1;
					end
					if (d[CMD_SET_RST_BIT]) begin
						p.rst = 1'b1;
						p.rst_cnt = RST_W'(RESET_CYCLES);
					end
				end
				if (d[CMD_CLR_EN_BIT]) begin
					p.en = 1'b0;
				end
				if (d[CMD_CLR_SUSP_BIT] && p.susp) begin
					p.susp = 1'b0;
					p.chg[CHG_SUSP] = 1'b1;
				end
				// per-port commands reach only masked ports
				if (st_reg.per_port_pwr && st_reg.pwr_mask[i]) begin
					if (d[CMD_SET_PWR_BIT]) begin
						p.pwr = 1'b1;
					end
					if (d[CMD_CLR_PWR_BIT]) begin
						p.pwr = 1'b0;
					end
				end
			end

			if (hub_wr && bus_req.wdata[HUB_SET_POWER_BIT]
					&& (!st_reg.per_port_pwr || !st_reg.pwr_mask[i])) begin
				p.pwr = 1'b1;
			end
			if (hub_wr && bus_req.wdata[HUB_CLR_POWER_BIT]
					&& (!st_reg.per_port_pwr || !st_reg.pwr_mask[i])) begin
				p.pwr = 1'b0;
			end

			// hardware events after writes so a set beats a clear
			conn_evt[i] = active[i] && (st_next.q[2 + i] != st_reg.q[2 + i]);
			p.conn = st_next.q[2 + i];
			p.ls = st_next.q[4 + i] && st_next.q[2 + i];
			if (conn_evt[i]) begin
				p.chg[CHG_CONN] = 1'b1;
				int_set[INT_CONNECT_BIT] = 1'b1;
				if (!st_next.q[2 + i]) begin
					if (p.en) begin
						p.chg[CHG_EN] = 1'b1;
					end
					p.en = 1'b0;
					p.susp = 1'b0;
				end
			end
			p.oc = st_reg.oc_per_port && st_next.q[i];
			if (p.oc != st_reg.port[i].oc) begin
				p.chg[CHG_OC] = 1'b1;
			end
			if (p.oc && p.en) begin
				p.en = 1'b0;
				p.chg[CHG_EN] = 1'b1;
			end
			// reset done sets its flag and drops suspend change
			if (p.rst) begin
				if (p.rst_cnt <= RST_W'(1)) begin
					p.rst = 1'b0;
					p.rst_cnt = '0;
					p.en = 1'b1;
					p.chg[CHG_RST] = 1'b1;
					p.chg[CHG_SUSP] = 1'b0;
				end else begin
					p.rst_cnt = p.rst_cnt - RST_W'(1);
				end
			end
			if (!active[i]) begin
				p = '0;
			end
			st_next.port[i] = p;
		end

		if (st_reg.wake_en && controller_suspend_state && |conn_evt) begin
			st_next.resume_req = 1'b1;
			int_set[INT_RESUME_BIT] = 1'b1;
		end

		// config register
		if (bus_req.wr && bus_req.addr == CONFIG_WR) begin
			st_next.per_port_pwr = bus_req.wdata[CFG_PER_PORT_PWR_BIT];
			st_next.oc_per_port = bus_req.wdata[CFG_OC_PER_PORT_BIT];
			st_next.pwr_mask = bus_req.wdata[CFG_MASK_LSB +: 2];
			st_next.port_count = bus_req.wdata[CFG_COUNT_LSB +: 2];
		end
		if (bus_req.wr && bus_req.addr == INT_MASK_WR) begin
			st_next.int_mask = bus_req.wdata[2:0];
		end
		// sticky interrupt bits: clear by one, new event wins
		if (bus_req.wr && bus_req.addr == INT_STATUS_WR) begin
			st_next.int_stat = st_reg.int_stat & ~bus_req.wdata[2:0];
		end
		st_next.int_stat = st_next.int_stat | int_set;
		st_next.irq = |(st_next.int_stat & st_next.int_mask);

		// read data in the cycle after the strobe only
		if (bus_req.rd) begin
			w = 32'h0;
			if (bus_req.addr == HUB_STATUS_RD) begin
				w[HUB_OC_CHG_BIT] = st_reg.hub_oc_chg;
				w[HUB_WAKE_BIT] = st_reg.wake_en;
				w[HUB_OC_BIT] = st_reg.hub_oc;
			end else if (bus_req.addr == PORT_RD_BASE) begin
				w = port_word(st_reg.port[0]);
			end else if (bus_req.addr == PORT_RD_BASE + 8'h01) begin
				w = port_word(st_reg.port[1]);
			end else if (bus_req.addr == CONFIG_RD) begin
				w[CFG_PER_PORT_PWR_BIT] = st_reg.per_port_pwr;
				w[CFG_OC_PER_PORT_BIT] = st_reg.oc_per_port;
				w[CFG_MASK_LSB +: 2] = st_reg.pwr_mask;
				w[CFG_COUNT_LSB +: 2] = st_reg.port_count;
			end else if (bus_req.addr == INT_STATUS_RD) begin
				w[2:0] = st_reg.int_stat;
			end else if (bus_req.addr == INT_MASK_RD) begin
				w[2:0] = st_reg.int_mask;
			end
			st_next.rdata = w;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.port_count <= CFG_COUNT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data = st_reg.rdata;
	assign irq = st_reg.irq;
	assign resume_req = st_reg.resume_req;
	assign port_power = {st_reg.port[1].pwr, st_reg.port[0].pwr};
	assign port_reset_out = {st_reg.port[1].rst, st_reg.port[0].rst};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence hub_write_s;
		bus_req.wr && bus_req.addr == HUB_STATUS_WR;
	endsequence
	sequence hub_read_s;
		bus_req.rd && bus_req.addr == HUB_STATUS_RD;
	endsequence
	sequence p0_plain_s;
		!st_reg.port[0].pend && !(bus_req.wr && bus_req.addr == PORT_WR_BASE);
	endsequence

	chk_clear_wake_bit: assert property (hub_write_s ##0 bus_req.wdata[31]
		&& !bus_req.wdata[15] |=> !st_reg.wake_en) else $error("wake enable not cleared");
	chk_hub_oc_change: assert property ($changed(st_reg.hub_oc) |-> st_reg.hub_oc_chg
		&& st_reg.int_stat[1]) else $error("overcurrent change not flagged");
	chk_local_power_zero: assert property (hub_read_s |=> rd_data[16] == 1'b0
		&& rd_data[0] == 1'b0) else $error("local power bits not zero");
	chk_global_power_on: assert property (hub_write_s ##0 bus_req.wdata[16]
		&& !bus_req.wdata[0] && !st_reg.per_port_pwr && st_reg.port_count == 2'h2
		|=> port_power == 2'h3) else $error("global set power missed a port");
	chk_masked_port_keep: assert property (hub_write_s ##0 st_reg.per_port_pwr
		&& st_reg.pwr_mask[0] ##0 p0_plain_s |=> $stable(port_power[0]))
		else $error("masked port took global power");
	chk_global_power_off: assert property (hub_write_s ##0 bus_req.wdata[0]
		&& !st_reg.per_port_pwr |=> port_power == 2'h0)
		else $error("global clear power missed a port");
	chk_unmasked_clear: assert property (hub_write_s ##0 bus_req.wdata[0]
		&& st_reg.per_port_pwr && !st_reg.pwr_mask[0] |=> !port_power[0])
		else $error("unmasked port kept power");
	chk_wake_resume: assert property (st_reg.wake_en && controller_suspend_state
		&& |conn_evt |=> resume_req && st_reg.int_stat[0] ##1 !resume_req)
		else $error("resume not raised");
	chk_set_wake_bit: assert property (hub_write_s ##0 bus_req.wdata[15]
		|=> st_reg.wake_en)
		else $error("wake enable not set");
	chk_oc_per_port: assert property (st_reg.oc_per_port && $past(st_reg.oc_per_port)
		|-> !st_reg.hub_oc) else $error("global overcurrent set in per-port mode");
	chk_defer_write: assert property (st_reg.port[0].pend && transaction_busy
		|=> st_reg.port[0].pend) else $error("port write applied while busy");
	chk_port_absent: assert property (st_reg.port_count == 2'h1
		&& bus_req.rd && bus_req.addr == PORT_RD_BASE + 8'h01 |=> rd_data == 32'h0)
		else $error("absent port not zero");
	chk_reset_done: assert property ($fell(st_reg.port[0].rst) && st_reg.port_count != 2'h0
		|-> st_reg.port[0].chg[4] && !st_reg.port[0].chg[2])
		else $error("reset done flag missing");

endmodule : root_hub_status_registers

// ### test/port_model.sv
`timescale 1ns/1ns
module port_model (
	// clock
	input wire logic ref_clk,
	// from the block
	input wire logic [1:0] port_power,
	// scenario controls
	input wire logic [1:0] attach,
	input wire logic [1:0] slow,
	input wire logic [1:0] fault,
	// port pins
	output logic [1:0] oc_sense_n,
	output logic [1:0] connect_sense,
	output logic [1:0] low_speed_sense
);
	// a fault only draws current on a powered port
	always_ff @(posedge ref_clk) begin
		oc_sense_n <= ~(fault & port_power);
		connect_sense <= attach;
		// pull-down holds the line low with nothing attached
		low_speed_sense <= attach & slow;
	end
endmodule : port_model

// ### test/tb.sv
`timescale 1ns/1ns
module tb;
	import rh_status_pkg::*;
	typedef struct packed {
		logic [1:0] op;
		logic [7:0] a;
		logic [31:0] d;
	} row_t;
	logic ref_clk;
	logic resetn;
	reg_req_t req;
	logic [31:0] rd_data;
	logic irq;
	logic [1:0] oc_sense_n;
	logic [1:0] connect_sense;
	logic [1:0] low_speed_sense;
	logic [1:0] port_power;
	logic [1:0] port_reset_out;
	logic busy;
	logic susp;
	logic resume_req;
	logic [1:0] attach;
	logic [1:0] slow;
	logic [1:0] fault;
	logic seen;
	int err_count;
	int cmp_count;
	row_t rows [0:21] = '{
		'{2'h0, 8'h14, 32'h0}, '{2'h1, 8'h94, 32'h8000}, '{2'h0, 8'h14, 32'h8000},
		'{2'h1, 8'h94, 32'h80000000}, '{2'h0, 8'h14, 32'h0}, '{2'h1, 8'h94, 32'h10000},
		'{2'h0, 8'h15, 32'h100}, '{2'h0, 8'h16, 32'h100}, '{2'h0, 8'h14, 32'h0},
		'{2'h1, 8'h94, 32'h1}, '{2'h0, 8'h15, 32'h0}, '{2'h0, 8'h16, 32'h0},
		'{2'h1, 8'ha0, 32'h29}, '{2'h1, 8'h94, 32'h10000}, '{2'h0, 8'h15, 32'h100},
		'{2'h0, 8'h16, 32'h0}, '{2'h1, 8'h96, 32'h100}, '{2'h2, 8'h0, 32'h0},
		'{2'h0, 8'h16, 32'h100}, '{2'h1, 8'h94, 32'h1}, '{2'h0, 8'h15, 32'h0},
		'{2'h0, 8'h16, 32'h100}
	};

	root_hub_status_registers #(.RESET_CYCLES(8)) root_hub_status_registers_inst (
		.ref_clk(ref_clk), .resetn(resetn), .bus_req(req), .rd_data(rd_data),
		.irq(irq), .oc_sense_n(oc_sense_n), .connect_sense(connect_sense),
		.low_speed_sense(low_speed_sense), .port_power(port_power),
		.port_reset_out(port_reset_out), .transaction_busy(busy),
		.controller_suspend_state(susp), .resume_req(resume_req)
	);
	port_model port_model_inst (
		.ref_clk(ref_clk), .port_power(port_power), .attach(attach), .slow(slow),
		.fault(fault), .oc_sense_n(oc_sense_n), .connect_sense(connect_sense),
		.low_speed_sense(low_speed_sense)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		@(negedge ref_clk);
		chk(rd_data, exp);
	endtask : rd
	task give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		#(4000 * 100);
		err_count++;
		give_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		req = '0;
		busy = 1'b0;
		susp = 1'b0;
		attach = 2'h0;
		slow = 2'h0;
		fault = 2'h0;
		err_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].op == 2'h0) begin
				rd(rows[i].a, rows[i].d);
			end else if (rows[i].op == 2'h1) begin
				wr(rows[i].a, rows[i].d);
			end else begin
				repeat (2) @(posedge ref_clk);
			end
		end
		$display("table done");
		// global overcurrent, change flag and interrupt
		wr(8'ha0, 32'h20);
		wr(8'h94, 32'h10000);
		wr(8'ha2, 32'h2);
		fault <= 2'h2;
		repeat (8) @(posedge ref_clk);
		rd(8'h14, 32'h20002);
		chk(irq, 1'b1);
		fault <= 2'h0;
		repeat (8) @(posedge ref_clk);
		rd(8'h14, 32'h20000);
		wr(8'h94, 32'h20000);
		rd(8'h14, 32'h0);
		wr(8'ha2, 32'h0);
		@(negedge ref_clk);
		chk(irq, 1'b0);
		wr(8'ha1, 32'h2);
		// per-port overcurrent keeps the global flag at zero
		wr(8'ha0, 32'h22);
		fault <= 2'h2;
		repeat (8) @(posedge ref_clk);
		rd(8'h14, 32'h0);
		// let the sensed fault settle before leaving per-port mode, or the global flag blips
		fault <= 2'h0;
		repeat (8) @(posedge ref_clk);
		wr(8'ha0, 32'h20);
		wr(8'ha1, 32'h7);
		$display("overcurrent done");
		// connect while suspended with wakeup enabled
		wr(8'h94, 32'h8000);
		susp <= 1'b1;
		attach <= 2'h1;
		slow <= 2'h1;
		seen = 1'b0;
		repeat (20) begin
			@(negedge ref_clk);
			if (resume_req === 1'b1) seen = 1'b1;
		end
		chk(seen, 1'b1);
		rd(8'h21, 32'h5);
		rd(8'h15, 32'h10301);
		susp <= 1'b0;
		$display("wakeup done");
		// port write held off by a running transaction
		busy <= 1'b1;
		wr(8'h95, 32'h10000);
		repeat (4) @(posedge ref_clk);
		rd(8'h15, 32'h10301);
		busy <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(8'h15, 32'h301);
		wr(8'h95, 32'h10);
		repeat (3) @(negedge ref_clk);
		chk(port_reset_out, 2'h1);
		repeat (20) @(posedge ref_clk);
		rd(8'h15, 32'h100303);
		$display("port write done");
		// one configured port, unmapped place
		wr(8'ha0, 32'h10);
		rd(8'h16, 32'h0);
		rd(8'h30, 32'h0);
		// reset in mid-run
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(port_power, 2'h0);
		chk(irq, 1'b0);
		@(posedge ref_clk);
		resetn <= 1'b1;
		rd(8'h14, 32'h0);
		rd(8'h20, 32'h20);
		$display("reset done");
		give_verdict();
	end
endmodule : tb
